// >>> cpu_model.sv
// cpu side model: issues a request and captures the result byte
// assumes the checker answers each request with one done pulse
`timescale 1ns/100ps
`default_nettype none
module cpu_model
  import prog_check_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic go_in,
  input wire prog_req_t req_val_in,
  input wire logic done_in,
  input wire logic [7:0] status_in,
  output logic start_out,
  output prog_req_t req_out,
  output logic [7:0] result_out
);
  initial begin
    start_out = 1'b0;
    req_out = '0;
    result_out = 8'h00;
  end
  // request fields stay put until the next request
  always @(posedge sys_clk_in) begin
    start_out <= go_in;
    if (go_in) req_out <= req_val_in;
    if (done_in) result_out <= status_in;
  end
endmodule // cpu_model
`default_nettype wire

// >>> flash_program_result_check.sv
// flash programming request checker returning an 8-bit result byte
// assumes the cpu holds request fields stable from start until done
`timescale 1ns/100ps
`default_nettype none
module flash_program_result_check
  import prog_check_pkg::*;
#(
  parameter logic [31:0] FLASH_LO = FLASH_BASE,
  parameter logic [31:0] FLASH_HI = FLASH_LAST,
  parameter int unsigned PROG_LEN = PROG_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire prog_req_t req_in,
  input wire logic flash_write_enable_pin_in,
  input wire logic error_protection_flag_in,
  input wire logic unerased_hit_in,
  output logic write_strobe_out,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] program_result_status_out
);
  function automatic logic in_flash(input logic [31:0] a);
    in_flash = (a >= FLASH_LO) && (a <= FLASH_HI);
  endfunction

  prog_state_t state_q, state_d;
  prog_req_t req_q;
  logic [7:0] status_q, status_d;
  logic timer_done, timer_start, unerased_q;

  wire mode_err = !flash_write_enable_pin_in || error_protection_flag_in;
  wire key_err = req_q.key_value != KEY_GOOD;
  wire data_err = in_flash(req_q.data_addr);
  wire dest_range_err = !in_flash(req_q.dest_addr);
  wire dest_align_err = (req_q.dest_addr[7:0] != ALIGN_LO) &&
                        (req_q.dest_addr[7:0] != ALIGN_HI);
  wire boot_sel = req_q.array_select == ARRAY_BOOT;
  wire pre_fail = mode_err || key_err || data_err || dest_range_err || dest_align_err;
  // a hit in the last programming cycle still counts
  wire exec_err = boot_sel || unerased_q || unerased_hit_in;
  assign timer_start = (state_q == ST_CHECK) && !pre_fail && !boot_sel;

  always_comb begin
    state_d = state_q;
    status_d = status_q;
    unique case (state_q)
      ST_IDLE: if (start_in) state_d = ST_CHECK;
      ST_CHECK: begin
        status_d = STATUS_RESET;
        status_d[BIT_MODE] = mode_err;
        status_d[BIT_KEY] = key_err;
        status_d[BIT_DATA] = data_err;
        status_d[BIT_DEST] = dest_range_err || dest_align_err;
        status_d[BIT_EXEC] = !pre_fail && boot_sel;
        status_d[BIT_SUCCESS_FAIL] = pre_fail || boot_sel;
        state_d = timer_start ? ST_PROG : ST_DONE;
      end
      ST_PROG: if (timer_done) begin
        status_d[BIT_EXEC] = exec_err;
        status_d[BIT_SUCCESS_FAIL] = exec_err;
        state_d = ST_DONE;
      end
      ST_DONE: state_d = ST_IDLE;
    endcase
    status_d[7] = 1'b0;
    status_d[3] = 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      status_q <= STATUS_RESET;
      unerased_q <= 1'b0;
    end else begin
      state_q <= state_d;
      status_q <= status_d;
      if (state_q == ST_IDLE && start_in) req_q <= req_in;
      if (timer_start) unerased_q <= 1'b0;
      else if (state_q == ST_PROG && unerased_hit_in) unerased_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      write_strobe_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      program_result_status_out <= STATUS_RESET;
    end else begin
      write_strobe_out <= state_d == ST_PROG;
      busy_out <= state_d != ST_IDLE;
      done_out <= state_d == ST_DONE;
      program_result_status_out <= status_d;
    end
  end

  prog_timer #(.CYCLES(PROG_LEN)) u_timer (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .start_in(timer_start),
    .done_out(timer_done)
  );

  property p_unused_zero;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      !program_result_status_out[7] && !program_result_status_out[3];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_mode;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK |=> program_result_status_out[BIT_MODE] == $past(mode_err);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit wrong");

  property p_refuse;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && mode_err |=> !write_strobe_out [*3];
  endproperty
  a_refuse: assert property (p_refuse) else $error("wrote while refused");

  property p_boot;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && boot_sel |=> !write_strobe_out && done_out;
  endproperty
  a_boot: assert property (p_boot) else $error("boot array touched");

  property p_key;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK |=> program_result_status_out[BIT_KEY] == $past(key_err);
  endproperty
  a_key: assert property (p_key) else $error("key bit wrong");

  property p_data;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK |=> program_result_status_out[BIT_DATA] == $past(data_err);
  endproperty
  a_data: assert property (p_data) else $error("data addr bit wrong");

  property p_dest;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK |=> program_result_status_out[BIT_DEST] ==
        ($past(dest_range_err) || $past(dest_align_err));
  endproperty
  a_dest: assert property (p_dest) else $error("dest addr bit wrong");

  property p_exec;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_PROG && timer_done |=> program_result_status_out[BIT_EXEC] ==
        $past(exec_err) && done_out;
  endproperty
  a_exec: assert property (p_exec) else $error("exec bit wrong");

  property p_success_fail;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      done_out |-> program_result_status_out[BIT_SUCCESS_FAIL] ==
        (|program_result_status_out[6:1]);
  endproperty
  a_success_fail: assert property (p_success_fail) else $error("success bit wrong");

  property p_busy_go;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_IDLE && start_in |=> busy_out && !done_out;
  endproperty
  a_busy_go: assert property (p_busy_go) else $error("request not taken");

  property p_done_one;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      done_out |=> !done_out;
  endproperty
  a_done_one: assert property (p_done_one) else $error("done longer than one cycle");

  property p_done_free;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      done_out |=> !busy_out;
  endproperty
  a_done_free: assert property (p_done_free) else $error("busy after done");

  property p_idle_quiet;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_IDLE && !start_in |=> !busy_out && !write_strobe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while idle");

  property p_ref_done;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && pre_fail |=>
        done_out && program_result_status_out[BIT_SUCCESS_FAIL];
  endproperty
  a_ref_done: assert property (p_ref_done) else $error("refusal not reported");

  property p_ref_exec;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && pre_fail |=> !program_result_status_out[BIT_EXEC];
  endproperty
  a_ref_exec: assert property (p_ref_exec) else $error("exec bit on refusal");

  property p_ws_busy;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      write_strobe_out |-> busy_out;
  endproperty
  a_ws_busy: assert property (p_ws_busy) else $error("strobe while not busy");

  property p_ws_rise;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(write_strobe_out) |-> $past(timer_start);
  endproperty
  a_ws_rise: assert property (p_ws_rise) else $error("strobe without clean check");

  property p_ws_stop;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_PROG && timer_done |=> !write_strobe_out && done_out;
  endproperty
  a_ws_stop: assert property (p_ws_stop) else $error("strobe past end");

  property p_we_low;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && !flash_write_enable_pin_in |=>
        program_result_status_out[BIT_MODE] && !write_strobe_out;
  endproperty
  a_we_low: assert property (p_we_low) else $error("pin low not refused");

  property p_prot_set;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && error_protection_flag_in |=>
        program_result_status_out[BIT_MODE] && !write_strobe_out;
  endproperty
  a_prot_set: assert property (p_prot_set) else $error("protection not refused");

  property p_mode_ok;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && flash_write_enable_pin_in && !error_protection_flag_in |=>
        !program_result_status_out[BIT_MODE];
  endproperty
  a_mode_ok: assert property (p_mode_ok) else $error("mode bit set when normal");

  property p_key_ok;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && req_q.key_value == KEY_GOOD |=>
        !program_result_status_out[BIT_KEY];
  endproperty
  a_key_ok: assert property (p_key_ok) else $error("good key flagged");

  property p_key_bad;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && req_q.key_value != KEY_GOOD |=>
        program_result_status_out[BIT_KEY] && !write_strobe_out;
  endproperty
  a_key_bad: assert property (p_key_bad) else $error("bad key not refused");

  property p_data_in;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && req_q.data_addr >= FLASH_LO && req_q.data_addr <= FLASH_HI |=>
        program_result_status_out[BIT_DATA];
  endproperty
  a_data_in: assert property (p_data_in) else $error("source in flash missed");

  property p_dest_out;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && req_q.dest_addr > FLASH_HI |=>
        program_result_status_out[BIT_DEST] && done_out;
  endproperty
  a_dest_out: assert property (p_dest_out) else $error("dest outside flash missed");

  property p_dest_odd;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && req_q.dest_addr[6:0] != 7'h00 |=>
        program_result_status_out[BIT_DEST];
  endproperty
  a_dest_odd: assert property (p_dest_odd) else $error("unaligned dest missed");

  property p_dest_ok;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && req_q.dest_addr[6:0] == 7'h00 &&
        req_q.dest_addr >= FLASH_LO && req_q.dest_addr <= FLASH_HI |=>
        !program_result_status_out[BIT_DEST];
  endproperty
  a_dest_ok: assert property (p_dest_ok) else $error("good dest flagged");

  property p_boot_flag;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_CHECK && !pre_fail && boot_sel |=>
        program_result_status_out[BIT_EXEC] && program_result_status_out[BIT_SUCCESS_FAIL];
  endproperty
  a_boot_flag: assert property (p_boot_flag) else $error("boot select not flagged");

  property p_uner_rep;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_PROG && timer_done && (unerased_q || unerased_hit_in) |=>
        program_result_status_out[BIT_EXEC] && program_result_status_out[BIT_SUCCESS_FAIL];
  endproperty
  a_uner_rep: assert property (p_uner_rep) else $error("unerased hit lost");

  property p_uner_latch;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_PROG && unerased_hit_in && !timer_done |=> unerased_q;
  endproperty
  a_uner_latch: assert property (p_uner_latch) else $error("unerased hit not held");

  property p_clean;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_PROG && timer_done && !unerased_q && !unerased_hit_in |=>
        program_result_status_out == 8'h00;
  endproperty
  a_clean: assert property (p_clean) else $error("clean run not reported");

  property p_hold;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      state_q == ST_IDLE || state_q == ST_DONE |=> $stable(program_result_status_out);
  endproperty
  a_hold: assert property (p_hold) else $error("result byte changed");
endmodule // flash_program_result_check
`default_nettype wire

// >>> prog_check_pkg.sv
// constants and types for the flash programming result checker
// assumes one 40 MHz clock domain shared with the cpu
package prog_check_pkg;
  localparam int unsigned STATUS_W = 8;
  localparam int unsigned BIT_MODE = 6;
  localparam int unsigned BIT_EXEC = 5;
  localparam int unsigned BIT_KEY = 4;
  localparam int unsigned BIT_DATA = 2;
  localparam int unsigned BIT_DEST = 1;
  localparam int unsigned BIT_SUCCESS_FAIL = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] KEY_GOOD = 8'h5a;
  localparam logic [7:0] ARRAY_BOOT = 8'haa;
  localparam logic [7:0] ALIGN_LO = 8'h00;
  localparam logic [7:0] ALIGN_HI = 8'h80;
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_LAST = 32'h0001_ffff;
  localparam int unsigned PROG_CYCLES = 16;

  typedef struct packed {
    logic [31:0] dest_addr;
    logic [31:0] data_addr;
    logic [7:0] key_value;
    logic [7:0] array_select;
  } prog_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_PROG = 2'b11,
    ST_DONE = 2'b10
  } prog_state_t;
endpackage

// >>> prog_timer.sv
// countdown that paces the programming phase
// assumes start pulses only when idle
`timescale 1ns/100ps
`default_nettype none
module prog_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  output logic done_out
);
  logic [7:0] cnt_q;
  logic run_q;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= run_q && (cnt_q == 8'h01);
      if (start_in) begin
        cnt_q <= 8'(CYCLES);
        run_q <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) run_q <= 1'b0;
      end
    end
  end
endmodule // prog_timer
`default_nettype wire

// >>> tb.sv
// self-checking bench for the programming result checker
// assumes the cpu model drives start and request fields
`timescale 1ns/100ps
`default_nettype none
module tb;
  import prog_check_pkg::*;
  localparam int PL = 4;
  localparam logic [31:0] D_OK = 32'h0000_0100;
  localparam logic [31:0] S_OK = 32'h0010_0000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic we = 1'b1;
  logic prot = 1'b0;
  logic hit = 1'b0;
  prog_req_t val = '0;
  prog_req_t req;
  logic start, ws, busy, done;
  logic [7:0] status, result;
  int failures = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  cpu_model cpu (.sys_clk_in(clk), .go_in(go), .req_val_in(val), .done_in(done),
    .status_in(status), .start_out(start), .req_out(req), .result_out(result));
  flash_program_result_check #(.PROG_LEN(PL)) DUT (.sys_clk_in(clk), .nrst_in(nrst),
    .start_in(start), .req_in(req), .flash_write_enable_pin_in(we),
    .error_protection_flag_in(prot), .unerased_hit_in(hit), .write_strobe_out(ws),
    .busy_out(busy), .done_out(done), .program_result_status_out(status));
  task automatic summarize();
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // pins = {write enable, protection, unerased hit}
  task automatic run(input prog_req_t r, input logic [2:0] pins, input logic [7:0] exp,
                     input int lat);
    int n;
    int s;
    int b;
    n = 0;
    s = 0;
    b = 0;
    {we, prot, hit} <= pins;
    go <= 1'b1;
    val <= r;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
      s += int'(ws);
      b += int'(busy);
      if (n > 60) begin
        failures++;
        summarize();
      end
    end while (done !== 1'b1);
    @(posedge clk);
    #1;
    chk("status", {24'h0, result}, {24'h0, exp});
    chk("latency", n, lat);
    chk("strobe", s, (lat == 2) ? 0 : PL + 1);
    chk("busy", b, lat);
    chk("done and busy after", {30'h0, done, busy}, 32'h0000_0000);
  endtask
  task automatic t_good();
    run('{D_OK, S_OK, KEY_GOOD, 8'h00}, 3'b100, 8'h00, PL + 3);
    run('{32'h0000_0180, S_OK, KEY_GOOD, 8'h00}, 3'b100, 8'h00, PL + 3);
  endtask
  task automatic t_mode();
    run('{D_OK, S_OK, KEY_GOOD, 8'h00}, 3'b000, 8'h41, 2);
    run('{D_OK, S_OK, KEY_GOOD, 8'h00}, 3'b110, 8'h41, 2);
    run('{D_OK, S_OK, 8'h5b, 8'h00}, 3'b000, 8'h51, 2);
  endtask
  task automatic t_key();
    run('{D_OK, S_OK, 8'h00, 8'h00}, 3'b100, 8'h11, 2);
  endtask
  task automatic t_addr();
    run('{D_OK, 32'h0001_fff0, KEY_GOOD, 8'h00}, 3'b100, 8'h05, 2);
    run('{32'h0002_0000, S_OK, KEY_GOOD, 8'h00}, 3'b100, 8'h03, 2);
    run('{32'h0000_0140, S_OK, KEY_GOOD, 8'h00}, 3'b100, 8'h03, 2);
  endtask
  task automatic t_exec();
    run('{D_OK, S_OK, KEY_GOOD, ARRAY_BOOT}, 3'b100, 8'h21, 2);
    run('{D_OK, S_OK, KEY_GOOD, 8'h00}, 3'b101, 8'h21, PL + 3);
    run('{D_OK, S_OK, KEY_GOOD, 8'h00}, 3'b100, 8'h00, PL + 3);
  endtask
  // reset in the middle of programming, then a fresh request
  task automatic t_reset();
    {we, prot, hit} <= 3'b100;
    val <= '{D_OK, S_OK, KEY_GOOD, 8'h00};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("strobe before reset", {31'h0, ws}, 32'h0000_0001);
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    chk("outputs in reset", {21'h0, ws, busy, done, status}, 32'h0000_0000);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    run('{D_OK, S_OK, KEY_GOOD, 8'h00}, 3'b100, 8'h00, PL + 3);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_good();
    t_mode();
    t_key();
    t_addr();
    t_exec();
    t_reset();
    summarize();
  end
endmodule // tb
`default_nettype wire
